//--- inc/debugger_defs.svh
// constants of the debugger control and status block
`ifndef DEBUGGER_DEFS_SVH
`define DEBUGGER_DEFS_SVH

`define CMD_WR_COUNTER 8'h01
`define CMD_RD_STATUS 8'h02
`define CMD_RD_COUNTER 8'h03
`define CMD_WR_CONTROL 8'h04
`define CMD_RD_CONTROL 8'h05

`define CTL_HALT_BIT 7
`define CTL_BRK_EN_BIT 6
`define CTL_ACK_EN_BIT 5
`define CTL_LOOP_BIT 4
`define CTL_PC_BRK_BIT 3
`define CTL_ZERO_BRK_BIT 2
`define CTL_RSVD_BIT 1
`define CTL_DEV_RST_BIT 0
`define CTL_RESET 8'h00
`define CTL_WRITE_MASK 8'hEF

`define STAT_IDLE_BIT 7
`define STAT_HALT_BIT 6
`define STAT_READ_PROTECT_FLAG_BIT 5
`define STAT_RESET 8'h00

`define ACK_BYTE 8'hFF
`define COUNTER_CLEAR 16'h0000
`define NOT_DEBUG_READ 16'hFFFF
`define DEV_RESET_CYCLES 16

`endif

//--- inc/debugger_pkg.sv
// types shared by the debugger control and status block
package debugger_pkg;

    // one debugger command as delivered by the serial command decoder
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } rsp_t;

    typedef struct packed {
        logic req;
        logic [7:0] data;
    } ack_t;

    typedef struct packed {
        logic brk_decode;
        logic [15:0] pc;
        logic halt_mode;
    } core_t;

    typedef struct packed {
        logic halt;
        logic brk_en;
        logic ack_en;
        logic loop;
        logic pc_brk;
        logic zero_brk;
        logic rsvd;
        logic dev_rst;
    } ctl_t;

    typedef enum logic [1:0] {
        RS_IDLE,
        RS_HOLD,
        RS_DONE
    } rst_state_t;

endpackage : debugger_pkg

//--- logic/debug_counter_unit.sv
// down counter of system clock cycles used for hardware breaks
`timescale 1ns/1ps
`include "debugger_defs.svh"
module debug_counter_unit #(
    parameter int WIDTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_load_val,
    input wire logic i_clear,
    input wire logic i_count_en,
    output logic [WIDTH-1:0] o_value,
    output logic o_reached_zero
);
    typedef struct packed {
        logic [WIDTH-1:0] value;
        logic zero;
    } cnt_state_t;

    cnt_state_t q;
    cnt_state_t d;

    initial
    begin
        if (WIDTH < 2)
        begin
            $error("debug_counter_unit: WIDTH must be at least 2");
        end
    end

    always_comb
    begin
        d = q;
        d.zero = 1'b0;
        if (i_load)
        begin
            d.value = i_load_val;
        end
        else if (i_clear)
        begin
            d.value = WIDTH'(`COUNTER_CLEAR);
        end
        else if (i_count_en)
        begin
            d.value = q.value - WIDTH'(1);
            d.zero = (q.value == WIDTH'(1));
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_value = q.value;
    assign o_reached_zero = q.zero;

endmodule : debug_counter_unit

//--- logic/device_reset_seq.sv
// device reset sequencer that leaves the debugger untouched
`timescale 1ns/1ps
`include "debugger_defs.svh"
module device_reset_seq #(
    parameter int HOLD_CYCLES = `DEV_RESET_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    output logic o_dev_reset,
    output logic o_done
);
    import debugger_pkg::*;

    typedef struct packed {
        rst_state_t state;
        logic [15:0] count;
        logic dev_reset;
    } seq_state_t;

    seq_state_t q;
    seq_state_t d;

    initial
    begin
        if (HOLD_CYCLES < 1 || HOLD_CYCLES > 65535)
        begin
            $error("device_reset_seq: HOLD_CYCLES out of range");
        end
    end

    always_comb
    begin
        d = q;
        case (q.state)
            RS_IDLE:
            begin
                if (i_start)
                begin
                    d.state = RS_HOLD;
                    d.count = 16'(HOLD_CYCLES - 1);
                    d.dev_reset = 1'b1;
                end
            end
            RS_HOLD:
            begin
                if (q.count == 16'h0000)
                begin
                    d.state = RS_DONE;
                    d.dev_reset = 1'b0;
                end
                else
                begin
                    d.count = q.count - 16'h0001;
                end
            end
            RS_DONE:
            begin
                d.state = RS_IDLE;
            end
            default:
            begin
                d.state = RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            q <= '{state: RS_IDLE, count: 16'h0000, dev_reset: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    assign o_dev_reset = q.dev_reset;
    assign o_done = (q.state == RS_DONE);

endmodule : device_reset_seq

//--- logic/debugger_control_status.sv
// debugger control and status registers, breakpoints and device reset
`timescale 1ns/1ps
`include "debugger_defs.svh"
module debugger_control_status #(
    parameter int RESET_CYCLES = `DEV_RESET_CYCLES
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire debugger_pkg::cmd_t I_CMD,
    input wire debugger_pkg::core_t I_CORE,
    input wire logic I_LOOP_SELECT,
    input wire logic I_READ_PROTECT_OPT,
    input wire logic I_ACK_TAKEN,
    output debugger_pkg::rsp_t O_RSP,
    output debugger_pkg::ack_t O_ACK,
    output logic O_CPU_STOP,
    output logic O_BRK_ENABLE,
    output logic O_BRK_LOOP,
    output logic O_DEV_RESET
);
    import debugger_pkg::*;

    typedef struct packed {
        ctl_t ctl;
        logic brk_seen;
        logic brk_loop;
        rsp_t rsp;
        ack_t ack;
    } top_state_t;

    top_state_t q;
    top_state_t d;

    logic [15:0] cnt_value;
    logic cnt_zero;
    logic cnt_load;
    logic cnt_clear;
    logic cnt_en;
    logic dev_reset;
    logic seq_done;
    logic rst_start;
    logic wr_ctl;
    logic brk_hit;
    logic hw_break;
    logic halt_evt;

    function automatic logic is_cmd(input cmd_t c, input logic [7:0] code);
        is_cmd = c.valid && (c.code == code);
    endfunction : is_cmd

    // the debugger ignores the core's breaks while it is held in device reset
    always_comb
    begin
        wr_ctl = is_cmd(I_CMD, `CMD_WR_CONTROL);
        rst_start = wr_ctl && I_CMD.data[`CTL_DEV_RST_BIT] && !q.ctl.dev_rst;
        brk_hit = I_CORE.brk_decode && q.ctl.brk_en && !dev_reset;
        hw_break = !q.ctl.halt && !dev_reset
            && ((q.ctl.pc_brk && (I_CORE.pc == cnt_value))
            || (q.ctl.zero_brk && cnt_zero));
        halt_evt = (brk_hit && !q.ctl.loop) || hw_break;
        cnt_load = is_cmd(I_CMD, `CMD_WR_COUNTER) && q.ctl.halt;
        // stops on the halting edge so a zero break leaves the count at zero
        cnt_en = !q.ctl.halt && !q.ctl.pc_brk && !dev_reset && !halt_evt;
    end

    // leaving debug mode restarts the count unless zero-break is armed
    assign cnt_clear = q.ctl.halt && !d.ctl.halt && !q.ctl.zero_brk;

    always_comb
    begin
        d = q;
        d.rsp.valid = 1'b0;
        d.ctl.loop = I_LOOP_SELECT;
        if (seq_done)
        begin
            d.ctl.dev_rst = 1'b0;
        end
        if (I_ACK_TAKEN && q.ack.req)
        begin
            d.ack.req = 1'b0;
            d.ctl.ack_en = 1'b0;
        end
        if (wr_ctl)
        begin
            // writes of 81H, 41H and 40h land here like any other value
            d.ctl = ctl_t'((I_CMD.data[7:0] & `CTL_WRITE_MASK)
                | ({7'h00, I_LOOP_SELECT} << `CTL_LOOP_BIT));
            // bit0 reads one only while a sequence really runs
            d.ctl.dev_rst = rst_start || (q.ctl.dev_rst && !seq_done);
            d.brk_seen = 1'b0;
        end
        // halt and brk_seen from hardware events win over a same-cycle write; a same-cycle ack clear blocks a new ack request
        if (halt_evt)
        begin
            d.ctl.halt = 1'b1;
        end
        if (brk_hit)
        begin
            d.brk_seen = 1'b1;
        end
        if ((brk_hit || hw_break) && d.ctl.ack_en && !q.ack.req)
        begin
            d.ack.req = 1'b1;
        end
        d.brk_loop = d.ctl.brk_en && d.ctl.loop;
        if (is_cmd(I_CMD, `CMD_RD_CONTROL))
        begin
            d.rsp = '{valid: 1'b1, data: {8'h00, q.ctl}};
        end
        else if (is_cmd(I_CMD, `CMD_RD_STATUS))
        begin
            d.rsp.valid = 1'b1;
            d.rsp.data = {8'h00, `STAT_RESET};
            d.rsp.data[`STAT_IDLE_BIT] = q.ctl.halt || q.brk_seen;
            d.rsp.data[`STAT_HALT_BIT] = I_CORE.halt_mode;
            d.rsp.data[`STAT_READ_PROTECT_FLAG_BIT] = !I_READ_PROTECT_OPT;
        end
        else if (is_cmd(I_CMD, `CMD_RD_COUNTER))
        begin
            d.rsp.valid = 1'b1;
            // inverted so the host sees an up count
            d.rsp.data = q.ctl.halt ? ~cnt_value : `NOT_DEBUG_READ;
        end
    end

    // only the debugger reset clears these; device reset spares them
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            q <= '{ctl: ctl_t'(`CTL_RESET), brk_seen: 1'b0, brk_loop: 1'b0,
                rsp: '{valid: 1'b0, data: 16'h0000},
                ack: '{req: 1'b0, data: `ACK_BYTE}};
        end
        else
        begin
            q <= d;
        end
    end

    debug_counter_unit #(
        .WIDTH(16)
    ) u_counter (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_load(cnt_load),
        .i_load_val(I_CMD.data),
        .i_clear(cnt_clear),
        .i_count_en(cnt_en),
        .o_value(cnt_value),
        .o_reached_zero(cnt_zero)
    );

    device_reset_seq #(
        .HOLD_CYCLES(RESET_CYCLES)
    ) u_reset_seq (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_start(rst_start),
        .o_dev_reset(dev_reset),
        .o_done(seq_done)
    );

    assign O_RSP = q.rsp;
    assign O_ACK = q.ack;
    assign O_CPU_STOP = q.ctl.halt;
    assign O_BRK_ENABLE = q.ctl.brk_en;
    assign O_BRK_LOOP = q.brk_loop;
    assign O_DEV_RESET = dev_reset;

endmodule : debugger_control_status

//--- test/dbg_cs_checker.sv
// port assertions for the debugger control and status block
`timescale 1ns/1ps
`include "debugger_defs.svh"
module dbg_cs_checker #(
    parameter int RESET_CYCLES = 2
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire debugger_pkg::cmd_t I_CMD,
    input wire debugger_pkg::core_t I_CORE,
    input wire logic I_READ_PROTECT_OPT,
    input wire logic I_ACK_TAKEN,
    input wire debugger_pkg::rsp_t O_RSP,
    input wire debugger_pkg::ack_t O_ACK,
    input wire logic O_CPU_STOP,
    input wire logic O_BRK_ENABLE,
    input wire logic O_BRK_LOOP,
    input wire logic O_DEV_RESET
);
    import debugger_pkg::*;
    int hi_cnt;
    logic wr_c, rd_c, rd_s;
    assign wr_c = I_CMD.valid && I_CMD.code == `CMD_WR_CONTROL;
    assign rd_c = I_CMD.valid && I_CMD.code == `CMD_RD_CONTROL;
    assign rd_s = I_CMD.valid && I_CMD.code == `CMD_RD_STATUS;
    // length of the device reset pulse, kept for the first low cycle and zero after that
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
        if (I_RST)
            hi_cnt <= 0;
        else
            hi_cnt <= O_DEV_RESET ? hi_cnt + 1 : 0;
    default clocking @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);
    AST_READ_ANSWER: assert property ((rd_c || rd_s) |=> O_RSP.valid)
        else $error("read not answered");
    AST_HALT_ENTRY: assert property (wr_c && I_CMD.data[7] |=> O_CPU_STOP)
        else $error("no halt after write");
    AST_RUN_RESUME: assert property (O_CPU_STOP && wr_c && I_CMD.data[7:0] == 8'h40
        && !I_CORE.brk_decode |=> !O_CPU_STOP && O_BRK_ENABLE) else $error("no resume");
    AST_BRK_HALT: assert property (I_CORE.brk_decode && O_BRK_ENABLE && !O_BRK_LOOP
        && !O_DEV_RESET |=> O_CPU_STOP) else $error("breakpoint did not halt");
    AST_ACK_HOLD: assert property (O_ACK.req && !I_ACK_TAKEN |=> O_ACK.req)
        else $error("ack dropped early");
    AST_ACK_DROP: assert property (O_ACK.req && I_ACK_TAKEN |=> !O_ACK.req)
        else $error("ack not cleared");
    AST_RST_CAUSE: assert property ($rose(O_DEV_RESET) |-> $past(wr_c) && $past(I_CMD.data[0]))
        else $error("device reset without write");
    AST_RST_LEN: assert property ($fell(O_DEV_RESET) |-> hi_cnt == RESET_CYCLES)
        else $error("device reset length wrong");
    AST_STATUS: assert property (rd_s |=> O_RSP.data[6] == $past(I_CORE.halt_mode)
        && O_RSP.data[5] == !$past(I_READ_PROTECT_OPT) && O_RSP.data[4:0] == 5'h00)
        else $error("status bits wrong");
endmodule : dbg_cs_checker

//--- test/debug_host_model.sv
// host model: sends debugger commands and takes acknowledge bytes
`timescale 1ns/1ps
`include "debugger_defs.svh"
module debug_host_model (
    input wire logic i_clk,
    input wire debugger_pkg::ack_t i_ack,
    input wire logic [3:0] i_ack_dly,
    output debugger_pkg::cmd_t o_cmd,
    output logic o_ack_taken
);
    import debugger_pkg::*;
    logic [3:0] wait_q = 4'h0;
    initial o_cmd = '0;
    initial o_ack_taken = 1'b0;
    task automatic send(input logic [7:0] code, input logic [15:0] data);
        o_cmd <= {1'b1, code, code == `CMD_WR_CONTROL ? data & 16'hFFFD : data};
        @(posedge i_clk);
        o_cmd.valid <= 1'b0;
        @(posedge i_clk);
    endtask : send
    // acknowledge taker that is prompt or slow, as i_ack_dly says
    always @(posedge i_clk)
    begin
        o_ack_taken <= i_ack.req === 1'b1 && !o_ack_taken && wait_q == i_ack_dly;
        if (i_ack.req === 1'b1 && !o_ack_taken)
        begin
            wait_q <= wait_q == i_ack_dly ? 4'h0 : wait_q + 4'h1;
        end
    end
endmodule : debug_host_model

//--- test/tb_top.sv
// testbench top for the debugger control and status block
`timescale 1ns/1ps
`include "debugger_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_top;
    import debugger_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    core_t core = '0;
    logic loop_sel = 1'b0;
    logic rp_opt = 1'b1;
    logic [3:0] ack_dly = 4'h0;
    cmd_t cmd;
    rsp_t rsp;
    ack_t ack;
    logic taken, stop, brk_en, brk_loop, dev_rst;
    logic [15:0] v;
    logic [15:0] rsp_q[$];
    int err_count = 0;
    int n_compared = 0;
    int m_ctl = 0;
    int m_idle = 0;
    always #50 clk = ~clk;
    always @(negedge clk)
        if (rsp.valid === 1'b1)
            rsp_q.push_back(rsp.data);
    debug_host_model u_host (.i_clk(clk), .i_ack(ack), .i_ack_dly(ack_dly), .o_cmd(cmd),
        .o_ack_taken(taken));
    debugger_control_status #(.RESET_CYCLES(2)) u_dut (.I_SYS_CLK(clk), .I_RST(rst),
        .I_CMD(cmd), .I_CORE(core), .I_LOOP_SELECT(loop_sel), .I_READ_PROTECT_OPT(rp_opt),
        .I_ACK_TAKEN(taken), .O_RSP(rsp), .O_ACK(ack), .O_CPU_STOP(stop),
        .O_BRK_ENABLE(brk_en), .O_BRK_LOOP(brk_loop), .O_DEV_RESET(dev_rst));
    task automatic stop_test();
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    // loop bit comes from the pin, reserved bit is always sent as zero
    task automatic wr_ctl(input int d);
        u_host.send(`CMD_WR_CONTROL, 16'(d));
        m_ctl = (d & 'hED) | (loop_sel ? 'h10 : 0);
        m_idle = 0;
    endtask : wr_ctl
    task automatic rd_chk(input logic [7:0] c, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        u_host.send(c, 16'h0000);
        v = rsp_q.size() ? rsp_q.pop_front() : 16'hXXXX;
        `CHK(v & m, e)
    endtask : rd_chk
    task automatic st_chk();
        rd_chk(`CMD_RD_STATUS, {8'h00, m_ctl[7] || m_idle != 0, core.halt_mode, !rp_opt, 5'h00});
    endtask : st_chk
    task automatic outs_chk();
        @(negedge clk);
        `CHK({stop, brk_en, brk_loop, dev_rst},
            {m_ctl[7], m_ctl[6], m_ctl[6] & m_ctl[4], m_ctl[0]})
        @(posedge clk);
    endtask : outs_chk
    task automatic breakpoint_opcode();
        core.brk_decode <= 1'b1;
        @(posedge clk);
        core.brk_decode <= 1'b0;
        @(posedge clk);
        if (m_ctl[6])
        begin
            m_idle = 1;
            m_ctl = m_ctl | (m_ctl[4] ? 0 : 'h80);
        end
    endtask : breakpoint_opcode
    task automatic wait_lvl(ref logic s, input logic lvl);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (s !== lvl && n < 40);
        @(posedge clk);
        if (n == 40)
        begin
            err_count++;
            $display("BAD %0t wait ran out", $time);
            stop_test();
        end
    endtask : wait_lvl
    initial
    begin
        void'($urandom(73240));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(`CMD_RD_CONTROL, 16'h0000);
        repeat (4)
        begin
            core.halt_mode <= 1'($urandom);
            rp_opt <= 1'($urandom);
            @(posedge clk);
            st_chk();
        end
        wr_ctl('h80);
        outs_chk();
        rd_chk(`CMD_RD_CONTROL, 16'h0080);
        st_chk();
        wr_ctl('h40);
        outs_chk();
        st_chk();
        wr_ctl('h00);
        breakpoint_opcode();
        outs_chk();
        st_chk();
        ack_dly <= 4'($urandom_range(7, 2));
        wr_ctl('h60);
        breakpoint_opcode();
        @(negedge clk);
        `CHK({ack.req, ack.data}, 9'h1FF)
        @(posedge clk);
        outs_chk();
        repeat (12) @(posedge clk);
        m_ctl = m_ctl & 'hDF;
        rd_chk(`CMD_RD_CONTROL, 16'h00C0);
        loop_sel <= 1'b1;
        @(posedge clk);
        wr_ctl('h40);
        breakpoint_opcode();
        outs_chk();
        st_chk();
        loop_sel <= 1'b0;
        @(posedge clk);
        wr_ctl('h84);
        u_host.send(`CMD_WR_COUNTER, 16'h0005);
        wr_ctl('h04);
        wait_lvl(stop, 1'b1);
        m_ctl = 'h84;
        rd_chk(`CMD_RD_COUNTER, 16'hFFFF);
        u_host.send(`CMD_WR_COUNTER, 16'h8000);
        wr_ctl('h04);
        wr_ctl('h84);
        rd_chk(`CMD_RD_COUNTER, 16'h8000, 16'hFF00);
        wr_ctl('h8C);
        u_host.send(`CMD_WR_COUNTER, 16'h1234);
        wr_ctl('h0C);
        outs_chk();
        core.pc <= 16'h1234;
        wait_lvl(stop, 1'b1);
        m_ctl = 'h8C;
        rd_chk(`CMD_RD_COUNTER, 16'hEDCB);
        wr_ctl('h81);
        outs_chk();
        wait_lvl(dev_rst, 1'b0);
        repeat (3) @(posedge clk);
        m_ctl = 'h80;
        rd_chk(`CMD_RD_CONTROL, 16'h0080);
        wr_ctl('h41);
        outs_chk();
        wait_lvl(dev_rst, 1'b0);
        repeat (3) @(posedge clk);
        m_ctl = 'h40;
        outs_chk();
        rd_chk(`CMD_RD_CONTROL, 16'h0040);
        u_host.send(8'h1B, 16'h0000);
        `CHK(rsp_q.size(), 0)
        stop_test();
    end
endmodule : tb_top
bind debugger_control_status dbg_cs_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
    .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_CMD(I_CMD), .I_CORE(I_CORE),
    .I_READ_PROTECT_OPT(I_READ_PROTECT_OPT), .I_ACK_TAKEN(I_ACK_TAKEN), .O_RSP(O_RSP),
    .O_ACK(O_ACK), .O_CPU_STOP(O_CPU_STOP), .O_BRK_ENABLE(O_BRK_ENABLE),
    .O_BRK_LOOP(O_BRK_LOOP), .O_DEV_RESET(O_DEV_RESET));
